// ### src/gmss_pkg.sv
package gmss_pkg;

    localparam int CLK_HZ          = 10_000_000;
    localparam int SAMPLE_HZ       = 1000;
    localparam int SAMPLE_CYCLES   = CLK_HZ / SAMPLE_HZ;
    localparam int SETTLE_US       = 1000;
    localparam int SETTLE_CYCLES   = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W           = 16;

    localparam int ST_INTEGRITY    = 7;
    localparam int ST_STARTUP      = 6;
    localparam int ST_OUTSIDE      = 5;
    localparam int ST_OVERLOAD     = 4;
    localparam int ST_CHAN_ERR     = 3;
    localparam int ST_CH_LSB       = 0;

    localparam logic [7:0] STATUS_RST = 8'h40;

    typedef enum logic [1:0] {
        GMSS_DG_PART   = 2'h0,
        GMSS_DG_SERIAL = 2'h1,
        GMSS_DG_CONFIG = 2'h2
    } gmss_dg_t;

    typedef enum logic [6:0] {
        GMSS_SETTLE    = 7'h01,
        GMSS_SYNC      = 7'h02,
        GMSS_SEND_PART = 7'h04,
        GMSS_SEND_SER  = 7'h08,
        GMSS_SEND_CFG  = 7'h10,
        GMSS_NORMAL    = 7'h20,
        GMSS_SERVICE   = 7'h40
    } gmss_state_t;

    typedef struct packed {
        logic       integrity;
        logic       outside;
        logic [2:0] overloadCh;
        logic [2:0] errorCh;
    } gmss_health_t;

    typedef struct packed {
        logic     reqValid;
        gmss_dg_t reqKind;
    } gmss_dgreq_t;

endpackage

// ### src/gmss_status_byte.sv
`timescale 1ns/1ps
`default_nettype none
module gmss_status_byte
    import gmss_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic         startUp,
    input  wire gmss_health_t health,
    output logic [7:0]        statusByte
);
    typedef struct packed {
        logic [7:0] status;
    } gmss_sb_state_t;

    gmss_sb_state_t state_ff;
    gmss_sb_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.status = '0;
        nxt_state.status[ST_INTEGRITY] = health.integrity;
        nxt_state.status[ST_STARTUP]   = startUp;
        nxt_state.status[ST_OUTSIDE]   = health.outside;
        nxt_state.status[ST_OVERLOAD]  = |health.overloadCh;
        nxt_state.status[ST_CHAN_ERR]  = |health.errorCh;
        // channel bits are shared: overload and error channels are merged
        nxt_state.status[ST_CH_LSB +: 3] = health.overloadCh
                                         | health.errorCh;
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff.status <= STATUS_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign statusByte = state_ff.status;
endmodule
`default_nettype wire

// ### src/gmss_mode_sequencer.sv
// What this block does
// - status bit7 integrity fault, bit6 start-up
// - status bit5 outside operating conditions
// - overload sets bit4, channels in bits2..0
// - channel error sets bit3, channels bits2..0
// - external reset active low, idle high
// - external reset forces whole controller into init
// - init on power, reset, command in normal mode, service exit
// - settle references, then synchronise channels first
// - send part, serial, config datagrams in order
// - after config datagram enter normal mode
// - normal mode answers identification datagram requests
// - starts measuring without host set-up
// - sample channels at 1000 per second
`timescale 1ns/1ps
`default_nettype none
module gmss_mode_sequencer
    import gmss_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int SAMPLE_CNT = SAMPLE_CYCLES
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic         external_reset_in,
    input  wire logic         resetCmd,
    input  wire logic         serviceEnterCmd,
    input  wire logic         serviceExitCmd,
    input  wire gmss_dgreq_t  hostReq,
    input  wire logic         syncDone,
    input  wire logic         dgDone,
    input  wire gmss_health_t health,
    output logic              chanReset,
    output logic              chanSyncStart,
    output var gmss_dgreq_t   dgSend,
    output logic              sampleTick,
    output logic              normalMode,
    output logic              serviceMode,
    output logic [7:0]        statusByte
);
    typedef struct packed {
        logic [1:0]       rstSync;
        gmss_state_t      mode;
        logic [CNT_W-1:0] settleCnt;
        logic [CNT_W-1:0] sampleCnt;
        logic             syncIssued;
        logic             sendIssued;
        logic             chanReset;
        logic             syncStart;
        gmss_dgreq_t      dgSend;
        logic             sampleTick;
        logic             reqPend;
        gmss_dg_t         reqKind;
    } gmss_seq_state_t;

    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CNT - 1);
    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CNT - 1);

    gmss_seq_state_t state_ff;
    gmss_seq_state_t nxt_state;
    logic            extResetAsserted;

    function automatic gmss_dgreq_t mk_req(input gmss_dg_t kind);
        gmss_dgreq_t r;
        r.reqValid = 1'b1;
        r.reqKind  = kind;
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] v);
        return v + 1'b1;
    endfunction

    // every way into init restarts the settle wait from zero, except the default recovery from an illegal mode, which keeps settleCnt
    function automatic gmss_seq_state_t go_init(input gmss_seq_state_t s);
        gmss_seq_state_t r;
        r            = s;
        r.mode       = GMSS_SETTLE;
        r.settleCnt  = '0;
        r.syncIssued = 1'b0;
        r.sendIssued = 1'b0;
        r.reqPend    = 1'b0;
        return r;
    endfunction

    // pin is low-active; an open pin idles high by the pad pull-up
    assign extResetAsserted = ~state_ff.rstSync[1];

    always_comb begin
        nxt_state = state_ff;
        // rstSync[0] only feeds rstSync[1]
        nxt_state.rstSync    = {state_ff.rstSync[0], external_reset_in};
        nxt_state.syncStart  = 1'b0;
        nxt_state.dgSend     = '0;
        nxt_state.sampleTick = 1'b0;
        nxt_state.chanReset  = 1'b0;
        // requests outside normal mode are dropped with no sign to the host
        if (hostReq.reqValid && state_ff.mode == GMSS_NORMAL) begin
            nxt_state.reqPend = 1'b1;
            nxt_state.reqKind = hostReq.reqKind;
        end
        case (state_ff.mode)
            GMSS_SETTLE: begin
                nxt_state.chanReset = 1'b1;
                if (state_ff.settleCnt == SETTLE_LAST) begin
                    nxt_state.mode      = GMSS_SYNC;
                    nxt_state.settleCnt = '0;
                end else begin
                    nxt_state.settleCnt = count_up(state_ff.settleCnt);
                end
            end
            GMSS_SYNC: begin
                if (!state_ff.syncIssued) begin
                    nxt_state.syncStart  = 1'b1;
                    nxt_state.syncIssued = 1'b1;
                end else if (syncDone) begin
                    nxt_state.mode       = GMSS_SEND_PART;
                    nxt_state.syncIssued = 1'b0;
                end
            end
            GMSS_SEND_PART: begin
                if (!state_ff.sendIssued) begin
                    nxt_state.dgSend     = mk_req(GMSS_DG_PART);
                    nxt_state.sendIssued = 1'b1;
                end else if (dgDone) begin
                    nxt_state.mode       = GMSS_SEND_SER;
                    nxt_state.sendIssued = 1'b0;
                end
            end
            GMSS_SEND_SER: begin
                if (!state_ff.sendIssued) begin
                    nxt_state.dgSend     = mk_req(GMSS_DG_SERIAL);
                    nxt_state.sendIssued = 1'b1;
                end else if (dgDone) begin
                    nxt_state.mode       = GMSS_SEND_CFG;
                    nxt_state.sendIssued = 1'b0;
                end
            end
            GMSS_SEND_CFG: begin
                if (!state_ff.sendIssued) begin
                    nxt_state.dgSend     = mk_req(GMSS_DG_CONFIG);
                    nxt_state.sendIssued = 1'b1;
                end else if (dgDone) begin
                    nxt_state.mode       = GMSS_NORMAL;
                    nxt_state.sendIssued = 1'b0;
                    // first tick lands a full period after entry
                    nxt_state.sampleCnt  = '0;
                end
            end
            GMSS_NORMAL: begin
                // sampling runs on its own, no host action needed
                if (state_ff.sampleCnt == SAMPLE_LAST) begin
                    nxt_state.sampleCnt  = '0;
                    nxt_state.sampleTick = 1'b1;
                end else begin
                    nxt_state.sampleCnt = count_up(state_ff.sampleCnt);
                end
                // one answer in flight at a time; newer request replaces
                if (state_ff.sendIssued) begin
                    if (dgDone) begin
                        nxt_state.sendIssued = 1'b0;
                    end
                end else if (state_ff.reqPend) begin
                    nxt_state.dgSend     = mk_req(state_ff.reqKind);
                    nxt_state.sendIssued = 1'b1;
                    nxt_state.reqPend    = hostReq.reqValid;
                end
                if (resetCmd) begin
                    nxt_state = go_init(nxt_state);
                end else if (serviceEnterCmd) begin
                    nxt_state.mode       = GMSS_SERVICE;
                    nxt_state.sendIssued = 1'b0;
                    nxt_state.reqPend    = 1'b0;
                end
            end
            GMSS_SERVICE: begin
                if (serviceExitCmd) begin
                    nxt_state = go_init(nxt_state);
                end
            end
            default: begin
                nxt_state.mode = GMSS_SETTLE;
            end
        endcase
        if (extResetAsserted) begin
            // whole controller returns to init; sync chain keeps running
            nxt_state            = '0;
            nxt_state.rstSync    = {state_ff.rstSync[0], external_reset_in};
            nxt_state.mode       = GMSS_SETTLE;
            nxt_state.chanReset  = 1'b1;
            nxt_state.dgSend     = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff         <= '0;
            // chain starts at idle-high so no false pin reset follows
            state_ff.rstSync <= 2'h3;
            state_ff.mode    <= GMSS_SETTLE;
            state_ff.dgSend  <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign chanReset     = state_ff.chanReset;
    assign chanSyncStart = state_ff.syncStart;
    assign dgSend        = state_ff.dgSend;
    assign sampleTick    = state_ff.sampleTick;
    assign normalMode    = (state_ff.mode == GMSS_NORMAL);
    assign serviceMode   = (state_ff.mode == GMSS_SERVICE);

    // service mode counts as started: the unit is up, just not measuring
    gmss_status_byte u_status (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .startUp    (~(normalMode | serviceMode)),
        .health     (health),
        .statusByte (statusByte)
    );
endmodule
`default_nettype wire

// ### testbench/gmss_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gmss_checker
    import gmss_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         reset_n,
    input wire logic         external_reset_in,
    input wire gmss_dgreq_t  hostReq,
    input wire logic         dgDone,
    input wire gmss_health_t health,
    input wire logic         chanReset,
    input wire logic         chanSyncStart,
    input wire gmss_dgreq_t  dgSend,
    input wire logic         sampleTick,
    input wire logic         normalMode,
    input wire logic         serviceMode,
    input wire logic [7:0]   statusByte
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // live levels, one register stage behind health and mode
    status_map_a: assert property (
        $past(reset_n) |-> statusByte == {$past(health.integrity),
        !$past(normalMode) && !$past(serviceMode), $past(health.outside),
        |$past(health.overloadCh), |$past(health.errorCh),
        $past(health.overloadCh) | $past(health.errorCh)})
        else $error("status byte mismatch");
    sync_pulse_a: assert property (chanSyncStart |=> !chanSyncStart)
        else $error("sync start longer than one cycle");
    sync_after_a: assert property (
        chanSyncStart |-> !chanReset && !normalMode)
        else $error("sync start while channels held");
    dg_pulse_a: assert property (dgSend.reqValid |=> !dgSend.reqValid)
        else $error("datagram request longer than one cycle");
    tick_mode_a: assert property (sampleTick |-> $past(normalMode))
        else $error("sample tick outside normal mode");
    // gap fixed for the shortened sim period of 10 cycles
    tick_gap_a: assert property (
        sampleTick |=> (!sampleTick) [*8] ##1 !sampleTick
        ##1 (sampleTick || !normalMode))
        else $error("sample tick spacing wrong");
    pin_reset_a: assert property (
        (!external_reset_in) [*4] |-> chanReset && !normalMode)
        else $error("pin reset not acted on");
    normal_entry_a: assert property ($rose(normalMode) |-> $past(dgDone))
        else $error("normal mode without finished datagram");
    req_answer_a: assert property (
        hostReq.reqValid && normalMode |-> ##[2:40] dgSend.reqValid)
        else $error("host request not answered");
    cover property ($rose(normalMode));
    cover property (dgSend.reqValid && normalMode);
    cover property ($rose(serviceMode));
endmodule
`default_nettype wire

// ### testbench/gmss_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module gmss_far_model
    import gmss_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [3:0]  dly,
    input  wire logic        chanSyncStart,
    input  wire gmss_dgreq_t dgSend,
    output logic             syncDone,
    output logic             dgDone
);
    int syncCnt = 0;
    int sendCnt = 0;
    initial begin
        syncDone = 1'b0;
        dgDone = 1'b0;
    end
    // counters rest at zero so a done pulse is never repeated
    always @(posedge ref_clk) begin
        syncDone <= (syncCnt == 1);
        dgDone <= (sendCnt == 1);
        syncCnt <= chanSyncStart ? int'(dly) : (syncCnt > 0 ? syncCnt - 1 : 0);
        sendCnt <= dgSend.reqValid ? int'(dly) : (sendCnt > 0 ? sendCnt - 1 : 0);
    end
endmodule
`default_nettype wire

// ### testbench/gyro_mode_status_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_mode_status_sequencer_tb_top
    import gmss_pkg::*;
;
    logic         ref_clk, reset_n, pinLow, resetCmd, svcIn, svcOut;
    logic         syncDone, dgDone, chanReset, chanSyncStart;
    logic         sampleTick, normalMode, serviceMode;
    logic [7:0]   statusByte;
    logic [3:0]   dly;
    gmss_dgreq_t  hostReq, dgSend;
    gmss_health_t health;
    tri1          pinLine;
    int           fail_count, comparisons, ticks;
    logic [1:0]   sent[$];
    logic [15:0]  rows[7] = '{16'h0000, 16'h8080, 16'h4020, 16'h2014,
                              16'h030B, 16'h0A1B, 16'hFFBF};
    assign pinLine = pinLow ? 1'b0 : 1'bz;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (chanSyncStart) sent.push_back(2'h3);
        if (dgSend.reqValid) sent.push_back(dgSend.reqKind);
        if (sampleTick) ticks++;
    end
    gmss_mode_sequencer #(.SETTLE_CNT(20), .SAMPLE_CNT(10)) u_dut (
        .ref_clk, .reset_n, .external_reset_in(pinLine), .resetCmd,
        .serviceEnterCmd(svcIn), .serviceExitCmd(svcOut), .hostReq,
        .syncDone, .dgDone, .health, .chanReset, .chanSyncStart, .dgSend,
        .sampleTick, .normalMode, .serviceMode, .statusByte);
    gmss_far_model u_far (.ref_clk, .dly, .chanSyncStart, .dgSend,
        .syncDone, .dgDone);
    task automatic cmp(logic [7:0] got, logic [7:0] exp, string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // expects sync start, then part, serial and config
    task automatic wait_init(string what);
        int i;
        for (i = 0; i < 300 && normalMode !== 1'b1; i++) cyc(1);
        if (i == 300) begin
            fail_count++;
            $display("ERROR %0t init hang", $time);
            conclude;
        end else begin
            cmp(8'(sent.size()), 8'h04, what);
            for (int k = 0; k < 4 && k < sent.size(); k++)
                cmp(8'(sent[k]), k == 0 ? 8'h03 : 8'(k - 1), what);
            sent.delete();
            $display("%s done", what);
        end
    endtask
    initial begin
        {ref_clk, reset_n, pinLow, resetCmd, svcIn, svcOut} = '0;
        hostReq = '0;
        health = '0;
        dly = 4'h3;
        cyc(16);
        cmp(statusByte, 8'h40, "reset status");
        $display("reset done");
        reset_n = 1'b1;
        wait_init("power-on");
        for (int r = 0; r < 7; r++) begin
            health = rows[r][15:8];
            cyc(2);
            cmp(statusByte, rows[r][7:0], "status");
        end
        $display("status rows done");
        health = '0;
        ticks = 0;
        cyc(100);
        cmp(8'(ticks), 8'h0A, "ticks");
        $display("tick rate done");
        for (int k = 0; k < 3; k++) begin
            hostReq = '{1'b1, gmss_dg_t'(k)};
            cyc(1);
            hostReq = '0;
            cyc(10);
            cmp(8'(sent.size()), 8'h01, "req count");
            cmp(8'(sent.pop_front()), 8'(k), "req kind");
        end
        $display("host requests done");
        svcIn = 1'b1;
        cyc(1);
        svcIn = 1'b0;
        cyc(2);
        cmp(8'(serviceMode), 8'h01, "service entry");
        hostReq = '{1'b1, GMSS_DG_PART};
        cyc(1);
        hostReq = '0;
        cyc(10);
        cmp(8'(sent.size()), 8'h00, "refused req");
        $display("service mode done");
        dly = 4'hF;
        svcOut = 1'b1;
        cyc(1);
        svcOut = 1'b0;
        wait_init("service exit");
        dly = 4'h1;
        resetCmd = 1'b1;
        cyc(1);
        resetCmd = 1'b0;
        wait_init("reset command");
        pinLow = 1'b1;
        cyc(10);
        cmp(8'({chanReset, normalMode}), 8'h02, "pin held");
        cmp(statusByte, 8'h40, "pin status");
        $display("pin hold done");
        pinLow = 1'b0;
        wait_init("pin reset");
        conclude;
    end
endmodule
bind gmss_mode_sequencer gmss_checker u_chk (.ref_clk, .reset_n,
    .external_reset_in, .hostReq, .dgDone, .health, .chanReset,
    .chanSyncStart, .dgSend, .sampleTick, .normalMode, .serviceMode,
    .statusByte);
`default_nettype wire
